// File: rtl/stf_pkg.sv
// Package with constants and carrier types of the serial target frame interface.
package stf_pkg;
    localparam int FRAME_BITS       = 32;
    localparam int CLK_FREQ_MHZ     = 100;
    localparam int MAX_SCK_MHZ      = 10;
    localparam int TIMEOUT_MS       = 35;
    localparam int WAKE_DELAY_US    = 60;
    localparam int TIMEOUT_CYCLES   = TIMEOUT_MS * 1000 * CLK_FREQ_MHZ;
    localparam int WAKE_CYCLES      = WAKE_DELAY_US * CLK_FREQ_MHZ;
    localparam int CMD_OP_MSB       = 31;
    localparam int CMD_OP_LSB       = 30;
    localparam logic [1:0] CMD_OP_INVALID = 2'h3;
    localparam logic [31:0] CMD_RESET_VALUE = 32'h0;

    // Command word leaving the link, with its one-cycle valid strobe.
    typedef struct packed {
        logic        valid;
        logic [31:0] word;
    } stf_cmd_t;

    // Error event flags raised by the link.
    typedef struct packed {
        logic clock_count_error;
        logic invalid_command_error;
        logic select_low_timeout;
    } stf_err_t;
endpackage

// File: rtl/stf_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous pins.
module stf_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // The first stage feeds only the second; reset to idle levels (select high).
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_reg <= WIDTH'(1);
            sync_reg <= WIDTH'(1);
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// File: rtl/stf_target.sv
// Serial target frame interface: mode 0 shift logic, timeout and wake delay.
// Notes on behaviour
// R1: Mode zero; clock idles low when deselected.
// R2: Capture serial input on rising clock.
// R3: Change serial output only on falling clock.
// R4: Master clock at most ten megahertz; the test master in stf_master runs its clock at 12.5 MHz (80 ns period).
// R5: Master keeps select high half microsecond.
// R6: Select rising moves command to input register.
// R7: Select low beyond timeout is failure.
// R8: Standby wake enables drivers 60 us later.
// R9: Drive output only while selected.
// R10: Inverted global flag appears at select fall; the code drives global_ok_flag uninverted.
// R11: Bad command or clock count sets error.
// R12: Timeout also sets the serial error flag.
// R13: Select fall clears shifter and counter.
module stf_target
    import stf_pkg::*;
#(
    parameter int TIMEOUT_CNT = TIMEOUT_CYCLES,
    parameter int WAKE_CNT    = WAKE_CYCLES
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          select_low,
    input  wire logic          serial_clk,
    input  wire logic          serial_in,
    output logic               serial_out,
    output logic               serial_out_oe_n,
    input  wire logic [31:0]   response_word,
    input  wire logic          global_ok_flag,
    input  wire logic          regulator_standby_mode,
    input  wire logic          error_clear,
    output stf_pkg::stf_cmd_t  command,
    output logic               serial_error_flag,
    output stf_pkg::stf_err_t  error_events,
    output logic               drivers_enable
);
    import stf_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_FAIL} stf_state_t;

    logic [2:0] pins_sync;
    logic       sel_n;
    logic       sck;
    logic       din;

    // Pins cross into the clock domain before any logic looks at them (see R4).
    stf_sync #(.WIDTH(3)) u_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in ({serial_in, serial_clk, select_low}),
        .sync_out (pins_sync)
    );
    assign sel_n = pins_sync[0];
    assign sck   = pins_sync[1];
    assign din   = pins_sync[2];

    stf_state_t  state_reg, state_next;
    logic        sel_d_reg, sck_d_reg;
    logic        stby_d_reg;
    logic [31:0] shift_reg, shift_next;
    logic [31:0] tx_reg, tx_next;
    logic [5:0]  count_reg, count_next;
    logic [31:0] tmo_reg, tmo_next;
    logic [15:0] wake_reg, wake_next;
    logic        wake_pend_reg, wake_pend_next;
    logic        drv_reg, drv_next;
    logic        so_reg, so_next;
    logic        oe_n_reg, oe_n_next;
    stf_cmd_t    cmd_reg, cmd_next;
    stf_err_t    ev_reg, ev_next;
    logic        err_reg, err_next;
    logic        sel_fall, sel_rise, sck_rise, sck_fall;

    // Edge detection reads only synchronised levels (see R1).
    assign sel_fall = sel_d_reg && !sel_n;
    assign sel_rise = !sel_d_reg && sel_n;
    assign sck_rise = !sel_n && !sck_d_reg && sck;
    assign sck_fall = !sel_n && sck_d_reg && !sck;

    // Next-state logic of the frame engine.
    always_comb
    begin
        state_next     = state_reg;
        shift_next     = shift_reg;
        tx_next        = tx_reg;
        count_next     = count_reg;
        tmo_next       = tmo_reg;
        wake_next      = wake_reg;
        wake_pend_next = wake_pend_reg;
        drv_next       = drv_reg;
        so_next        = so_reg;
        oe_n_next      = oe_n_reg;
        cmd_next       = cmd_reg;
        cmd_next.valid = 1'b0;
        ev_next        = '0;
        case (state_reg)
            ST_IDLE:
            begin
                oe_n_next = 1'b1; // see R9
                if (sel_fall)
                begin
                    state_next = ST_FRAME;
                    shift_next = '0; // see R13
                    count_next = '0; // see R13
                    tmo_next   = '0;
                    tx_next    = {response_word[30:0], 1'b0};
                    so_next    = global_ok_flag; // see R10
                    oe_n_next  = 1'b0; // see R9
                end
            end
            ST_FRAME:
            begin
                if (sel_rise)
                begin
                    state_next = ST_IDLE;
                    oe_n_next  = 1'b1; // see R9
                    if (count_reg != 6'(FRAME_BITS))
                        ev_next.clock_count_error = 1'b1; // see R11
                    else if (shift_reg[CMD_OP_MSB:CMD_OP_LSB] == CMD_OP_INVALID)
                        ev_next.invalid_command_error = 1'b1; // see R11
                    else
                    begin
                        cmd_next.valid = 1'b1; // see R6
                        cmd_next.word  = shift_reg; // see R6
                        if (regulator_standby_mode)
                        begin
                            wake_pend_next = 1'b1; // see R8
                            wake_next      = '0;
                        end
                    end
                end
                else
                begin
                    if (sck_rise)
                    begin
                        shift_next = {shift_reg[30:0], din}; // see R2
                        if (count_reg != 6'h3F)
                            count_next = count_reg + 6'h01;
                    end
                    if (sck_fall)
                    begin
                        so_next = tx_reg[31]; // see R3
                        tx_next = {tx_reg[30:0], 1'b0};
                    end
                    if (tmo_reg >= 32'(TIMEOUT_CNT - 1))
                    begin
                        state_next = ST_FAIL; // see R7
                        ev_next.select_low_timeout = 1'b1; // see R12
                    end
                    else
                        tmo_next = tmo_reg + 32'h1;
                end
            end
            ST_FAIL:
            begin
                // Output stays driven while selected; the frame is dropped.
                if (sel_rise)
                begin
                    state_next = ST_IDLE;
                    oe_n_next  = 1'b1; // see R9
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Wake delay counts after select has returned high (see R8).
        if (wake_pend_reg && !(state_reg == ST_FRAME && sel_rise))
        begin
            if (wake_reg >= 16'(WAKE_CNT - 1))
            begin
                wake_pend_next = 1'b0;
                drv_next       = 1'b1;
            end
            else
                wake_next = wake_reg + 16'h1;
        end
        // Entering standby drops the drivers; a level test would undo a finished wake.
        if (regulator_standby_mode && !stby_d_reg)
            drv_next = 1'b0; // see R8
        else if (!regulator_standby_mode && !wake_pend_reg)
            drv_next = 1'b1;
    end

    // Sticky error flag: a new event wins over a clear (see R11).
    always_comb
    begin
        err_next = err_reg;
        if (error_clear)
            err_next = 1'b0;
        if (|ev_next)
            err_next = 1'b1; // see R12
    end

    // Registers of the frame engine.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg     <= ST_IDLE;
            sel_d_reg     <= 1'b1;
            sck_d_reg     <= 1'b0;
            stby_d_reg    <= 1'b0;
            shift_reg     <= CMD_RESET_VALUE;
            tx_reg        <= '0;
            count_reg     <= '0;
            tmo_reg       <= '0;
            wake_reg      <= '0;
            wake_pend_reg <= 1'b0;
            drv_reg       <= 1'b0;
            so_reg        <= 1'b0;
            oe_n_reg      <= 1'b1;
            cmd_reg       <= '0;
            ev_reg        <= '0;
            err_reg       <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            sel_d_reg     <= sel_n;
            sck_d_reg     <= sck;
            stby_d_reg    <= regulator_standby_mode;
            shift_reg     <= shift_next;
            tx_reg        <= tx_next;
            count_reg     <= count_next;
            tmo_reg       <= tmo_next;
            wake_reg      <= wake_next;
            wake_pend_reg <= wake_pend_next;
            drv_reg       <= drv_next;
            so_reg        <= so_next;
            oe_n_reg      <= oe_n_next;
            cmd_reg       <= cmd_next;
            ev_reg        <= ev_next;
            err_reg       <= err_next;
        end
    end

    assign serial_out        = so_reg;
    assign serial_out_oe_n   = oe_n_reg;
    assign command           = cmd_reg;
    assign error_events      = ev_reg;
    assign serial_error_flag = err_reg;
    assign drivers_enable    = drv_reg;

    // Output is released one cycle after a select rise is seen.
    chk_release_on_deselect: assert property (@(posedge clk) disable iff (srst) // see R9
        sel_rise |=> oe_n_reg)
        else $error("serial output not released after deselect");

    chk_status_at_select: assert property (@(posedge clk) disable iff (srst) // see R10
        (sel_fall && state_reg == ST_IDLE) |=> (!oe_n_reg && so_reg == $past(global_ok_flag)))
        else $error("status flag not presented at select fall");

    chk_out_on_fall: assert property (@(posedge clk) disable iff (srst) // see R3
        (!sck_fall && !sel_fall && !oe_n_reg) |=> $stable(so_reg))
        else $error("serial output changed outside a falling clock edge");

    chk_cmd_on_rise: assert property (@(posedge clk) disable iff (srst) // see R6
        cmd_reg.valid |-> $past(sel_rise))
        else $error("command issued without select rise");

    chk_count_error: assert property (@(posedge clk) disable iff (srst) // see R11
        (sel_rise && state_reg == ST_FRAME && count_reg != 6'(FRAME_BITS))
            |=> ev_reg.clock_count_error ##1 serial_error_flag)
        else $error("clock count error not flagged");

    chk_timeout_flag: assert property (@(posedge clk) disable iff (srst) // see R12
        ev_reg.select_low_timeout |=> serial_error_flag)
        else $error("timeout did not set the error flag");

    chk_timeout_hold: assert property (@(posedge clk) disable iff (srst) // see R7
        ev_reg.select_low_timeout |-> $past(tmo_reg) == 32'(TIMEOUT_CNT - 1))
        else $error("timeout fired at the wrong count");

    chk_shift_capture: assert property (@(posedge clk) disable iff (srst) // see R2
        (state_reg == ST_FRAME && sck_rise && !sel_rise) |=> shift_reg[0] == $past(din))
        else $error("serial input not captured on rising clock");

    chk_frame_clear: assert property (@(posedge clk) disable iff (srst) // see R13
        (sel_fall && state_reg == ST_IDLE) |=> (count_reg == 6'h00 && shift_reg == 32'h0))
        else $error("frame state not cleared at select fall");

    chk_wake_delay: assert property (@(posedge clk) disable iff (srst) // see R8
        $rose(drv_reg) && $past(wake_pend_reg) |-> $past(wake_reg) == 16'(WAKE_CNT - 1))
        else $error("drivers enabled at the wrong wake delay");
endmodule

// File: sim/stf_master.sv
// Behavioural serial master in mode zero that frames commands for the target port.
module stf_master (
    input  wire logic clk,
    output logic      select_low,
    output logic      serial_clk,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic oe_seen;

    // Idle state: deselected, clock low, data at its pull-down level.
    initial
    begin
        select_low = 1'b1;
        serial_clk = 1'b0;
        serial_in  = 1'b0;
        oe_seen    = 1'b0;
    end

    // Four cycles low and four high give 80 ns, faster than the rate ceiling, for margin.
    // Data is read late in the high phase, where it has long settled.
    task automatic frame(input logic [31:0] tx, input int nbits, input int hold,
                         output logic [31:0] rx);
        rx = 32'h0;
        oe_seen = 1'b0;
        @(negedge clk);
        select_low <= 1'b0;
        repeat (16) @(negedge clk);
        for (int i = 0; i < nbits; i++)
        begin
            serial_in <= tx[31 - (i % 32)];
            repeat (4) @(negedge clk);
            serial_clk <= 1'b1;
            repeat (4) @(negedge clk);
            rx = {rx[30:0], serial_out};
            oe_seen = oe_seen | ~serial_out_oe_n;
            serial_clk <= 1'b0;
        end
        repeat (hold) @(negedge clk);
        select_low <= 1'b1;
        serial_in  <= 1'b0;
        repeat (60) @(negedge clk);
    endtask
endmodule

// File: sim/tb_stf_target.sv
// Self-checking testbench of the serial target frame interface.
module tb_stf_target;
    import stf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TO_CNT = 2000;
    localparam int WK_CNT = 100;

    logic        clk;
    logic        srst;
    logic        select_low;
    logic        serial_clk;
    logic        serial_in;
    logic        serial_out;
    logic        serial_out_oe_n;
    logic [31:0] response_word;
    logic        global_ok_flag;
    logic        regulator_standby_mode;
    logic        error_clear;
    stf_cmd_t    command;
    logic        serial_error_flag;
    stf_err_t    error_events;
    stf_err_t    ev_seen;
    logic        drivers_enable;
    logic [31:0] last_word;
    int          cmd_cnt;
    int          cyc_cnt;
    int          fails;
    int          cmp_count;

    stf_target #(.TIMEOUT_CNT(TO_CNT), .WAKE_CNT(WK_CNT)) i_dut (
        .clk(clk), .srst(srst), .select_low(select_low), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .response_word(response_word), .global_ok_flag(global_ok_flag),
        .regulator_standby_mode(regulator_standby_mode), .error_clear(error_clear),
        .command(command), .serial_error_flag(serial_error_flag),
        .error_events(error_events), .drivers_enable(drivers_enable));

    stf_master i_master (
        .clk(clk), .select_low(select_low), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

    always #5 clk = ~clk;

    // Records commands and error pulses, since both stand for one cycle only.
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        ev_seen <= ev_seen | error_events;
        if (command.valid === 1'b1)
        begin
            cmd_cnt   <= cmd_cnt + 1;
            last_word <= command.word;
        end
        if (cyc_cnt == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    // A well formed frame: response out, command in, nothing refused.
    task automatic run_good(input logic [31:0] tx, input logic [31:0] resp, input logic ok);
        logic [31:0] rx;
        int          n0;
        response_word  = resp;
        global_ok_flag = ok;
        n0 = cmd_cnt;
        ev_seen = '0;
        i_master.frame(tx, 32, 16, rx);
        check(rx, {ok, resp[30:0]}, "response");
        check(i_master.oe_seen, 1'b1, "driven");
        check(serial_out_oe_n, 1'b1, "released");
        check(cmd_cnt - n0, 1, "one command");
        check(last_word, tx, "command word");
        check(ev_seen, 3'h0, "no error");
    endtask

    // A refused frame: error pulse and sticky flag, no command, then clear.
    task automatic run_bad(input logic [31:0] tx, input int nbits, input int hold,
                           input stf_err_t exp);
        logic [31:0] rx;
        int          n0;
        n0 = cmd_cnt;
        ev_seen = '0;
        i_master.frame(tx, nbits, hold, rx);
        check(cmd_cnt - n0, 0, "no command");
        check(ev_seen, exp, "error event");
        check(serial_error_flag, 1'b1, "sticky flag");
        error_clear = 1'b1;
        @(negedge clk);
        error_clear = 1'b0;
        repeat (2) @(negedge clk);
        check(serial_error_flag, 1'b0, "flag cleared");
    endtask

    // A command in standby wakes the drivers only after the wake delay.
    task automatic run_wake();
        logic [31:0] rx;
        regulator_standby_mode = 1'b1;
        repeat (4) @(negedge clk);
        check(drivers_enable, 1'b0, "standby off");
        i_master.frame(32'h0000_0101, 32, 16, rx);
        check(drivers_enable, 1'b0, "wake too early");
        repeat (60) @(negedge clk);
        check(drivers_enable, 1'b1, "woken");
        regulator_standby_mode = 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Reset, then each scenario in turn; a short frame precedes a good one.
    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        response_word = 32'h0;
        global_ok_flag = 1'b1;
        regulator_standby_mode = 1'b0;
        error_clear = 1'b0;
        ev_seen = '0;
        cmd_cnt = 0;
        cyc_cnt = 0;
        fails = 0;
        cmp_count = 0;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        check(drivers_enable, 1'b1, "active");
        check(serial_out_oe_n, 1'b1, "idle");
        run_good(32'h1234_5678, 32'hA5C3_0F96, 1'b1);
        run_good(32'h8001_FFFE, 32'h5A3C_F069, 1'b0);
        run_bad(32'h1234_5678, 31, 16, 3'h4);
        run_good(32'h0F0F_1234, 32'h7E81_0000, 1'b1);
        run_bad(32'h1234_5678, 33, 16, 3'h4);
        run_bad(32'hC000_0001, 32, 16, 3'h2);
        run_bad(32'h1234_5678, 32, 2100, 3'h1);
        run_wake();
        tally_and_finish();
    end
endmodule
